// ---- ufc_pkg.sv ----
package ufc_pkg;
  // register offsets on the 4-bit register port
  localparam logic [3:0] UFC_OFF_TX_HOLDING = 4'h0;
  localparam logic [3:0] UFC_OFF_INTERRUPT_MASK = 4'h1;
  localparam logic [3:0] UFC_OFF_FIFO_CONTROL = 4'h2;
  localparam logic [3:0] UFC_OFF_INTERRUPT_ID = 4'h2;
  localparam logic [3:0] UFC_OFF_LINE_STATE = 4'h5;
  localparam logic [3:0] UFC_OFF_ENHANCED_FEATURE = 4'h8;
  localparam logic [3:0] UFC_OFF_RX_LEVEL_SETTING = 4'h9;
  localparam logic [3:0] UFC_OFF_TX_LEVEL_SETTING = 4'ha;
  localparam logic [3:0] UFC_OFF_FLOW_THRESHOLD_LOW = 4'hb;
  localparam logic [3:0] UFC_OFF_FLOW_THRESHOLD_HIGH = 4'hc;
  localparam logic [3:0] UFC_OFF_FIFO_CONTROL_SHADOW = 4'hd;

  // fifo_control fields
  localparam int UFC_FCR_ENABLE = 0;
  localparam int UFC_FCR_RX_FLUSH = 1;
  localparam int UFC_FCR_TX_FLUSH = 2;
  localparam int UFC_FCR_TX_TRIG_LSB = 4;
  localparam int UFC_FCR_RX_TRIG_LSB = 6;

  // interrupt_mask fields
  localparam int UFC_IM_RX = 0;
  localparam int UFC_IM_TX = 1;
  localparam int UFC_IM_LINE = 2;
  localparam int UFC_IM_MODEM = 3;
  localparam int UFC_IM_XOFF = 5;
  localparam int UFC_IM_RTS = 6;
  localparam int UFC_IM_CTS = 7;

  // enhanced_feature field that opens the upper identification bits
  localparam int UFC_EF_ENHANCED = 4;

  // reset values
  localparam logic [7:0] UFC_RST_REG = 8'h00;
  localparam logic [7:0] UFC_RST_ID = 8'h01;

  // 32-byte mode trigger tables
  localparam logic [7:0] UFC_RX_TRIG_0 = 8'h08;
  localparam logic [7:0] UFC_RX_TRIG_1 = 8'h10;
  localparam logic [7:0] UFC_RX_TRIG_2 = 8'h18;
  localparam logic [7:0] UFC_RX_TRIG_3 = 8'h1c;
  localparam logic [7:0] UFC_TX_TRIG_0 = 8'h10;
  localparam logic [7:0] UFC_TX_TRIG_1 = 8'h08;
  localparam logic [7:0] UFC_TX_TRIG_2 = 8'h18;
  localparam logic [7:0] UFC_TX_TRIG_3 = 8'h1e;

  // identification codes, bits 5:0
  localparam logic [5:0] UFC_ID_LINE = 6'h06;
  localparam logic [5:0] UFC_ID_RX_DATA = 6'h04;
  localparam logic [5:0] UFC_ID_RX_TIMEOUT = 6'h0c;
  localparam logic [5:0] UFC_ID_TX_EMPTY = 6'h02;
  localparam logic [5:0] UFC_ID_MODEM = 6'h00;
  localparam logic [5:0] UFC_ID_XOFF = 6'h10;
  localparam logic [5:0] UFC_ID_CTS_RTS = 6'h20;
  localparam logic [5:0] UFC_ID_NONE = 6'h01;

  typedef enum logic [1:0]
  {
    UFC_FL_IDLE = 2'b01,
    UFC_FL_BUSY = 2'b10
  } ufc_flush_t;
endpackage

// ---- ufc_top.sv ----
`timescale 1ns/1ps
// What this block does
// [RULE1] fifos on and low four mask bits clear: polled mode, no interrupt output.
// [RULE2] line state bit 0 is 1 while the receive fifo holds a byte.
// [RULE3] line state bits 4:1 report receive error kinds or a received break.
// [RULE4] line state bit 5 shows the transmit fifo is empty.
// [RULE5] line state bit 6 is set only when transmit fifo and shifter are empty.
// [RULE6] line state bit 7 flags a data error among bytes held in receive fifo.
// [RULE7] fifo control 7:6 picks receive trigger 8/16/24/28; reaching it raises rx ready.
// [RULE8] fifo control 5:4 picks transmit trigger 16/8/24/30; falling below raises tx empty.
// [RULE9] writing fifo control bit 2 flushes the transmit fifo, then self-clears.
// [RULE10] writing fifo control bit 1 flushes the receive fifo, then self-clears.
// [RULE11] fifo control bit 0 enables both fifos; disabled after reset.
// [RULE12] any nonzero level or threshold register makes level registers set triggers.
// [RULE13] identification read returns only the highest pending source.
// [RULE14] codes: line status 000110, rx data 000100, rx timeout 001100.
// [RULE15] codes: tx empty 000010, modem 000000, xoff 010000, cts/rts 100000.
// [RULE16] identification bits 7:6 read 11 with fifos on, 00 otherwise.
// [RULE17] identification bits 5:4 work only while enhanced feature bit 4 is set.
// [RULE18] xoff identification bit stays 1 until a matching xon is received.
// [RULE19] identification bit 0 is 0 while anything is pending, 1 otherwise.
// [RULE20] rx ready clears as soon as the receive count drops below trigger.
// [RULE21] tx empty clears on an identification read that reports it, or on a tx holding write.
// [RULE22] interrupt output follows any enabled pending source; code tracks the top one.
module ufc_top
  import ufc_pkg::*;
(
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic rstn_in,
  // register port
  input wire logic [3:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [7:0] rdata_out,
  // fifo and line state from the datapath
  input wire logic [7:0] rx_count_in,
  input wire logic [7:0] tx_count_in,
  input wire logic tx_shift_empty_in,
  input wire logic [3:0] rx_error_in,
  input wire logic rx_fifo_error_in,
  input wire logic rx_timeout_in,
  input wire logic modem_change_in,
  input wire logic xoff_match_in,
  input wire logic xon_match_in,
  input wire logic cts_rts_event_in,
  // controls to the datapath
  output logic fifo_enable_out,
  output logic rx_flush_out,
  output logic tx_flush_out,
  output logic tx_write_out,
  output logic [7:0] tx_data_out,
  output logic irq_out
);
  import ufc_pkg::*;

  logic rst_meta;
  logic rst_n;
  logic [7:0] fifo_control;
  logic [7:0] interrupt_mask;
  logic [7:0] enhanced_feature;
  logic [7:0] rx_level_setting;
  logic [7:0] tx_level_setting;
  logic [7:0] flow_threshold_low;
  logic [7:0] flow_threshold_high;
  logic [3:0] line_err;
  logic tx_empty_pend;
  logic xoff_pend;
  logic cts_rts_pend;
  logic tx_below_q;
  ufc_flush_t flush_state;
  ufc_flush_t next_flush_state;
  logic use_level_regs;
  logic [7:0] rx_trig;
  logic [7:0] tx_trig;
  logic tx_below;
  logic rx_ready_pend;
  logic polled;
  logic [5:0] next_id;
  logic any_pend;
  logic [7:0] line_state;
  logic [7:0] id_value;
  logic id_read;
  logic ls_read;
  logic fcr_write;

  // reset release through two flops
  always_ff @(posedge clk_sys_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  assign fcr_write = wr_in && (addr_in == UFC_OFF_FIFO_CONTROL);
  assign id_read = rd_in && (addr_in == UFC_OFF_INTERRUPT_ID);
  assign ls_read = rd_in && (addr_in == UFC_OFF_LINE_STATE);

  // software-written configuration
  always_ff @(posedge clk_sys_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      interrupt_mask <= UFC_RST_REG;
      enhanced_feature <= UFC_RST_REG;
      rx_level_setting <= UFC_RST_REG;
      tx_level_setting <= UFC_RST_REG;
      flow_threshold_low <= UFC_RST_REG;
      flow_threshold_high <= UFC_RST_REG;
    end
    else if (wr_in)
    begin
      case (addr_in)
        UFC_OFF_INTERRUPT_MASK: interrupt_mask <= wdata_in;
        UFC_OFF_ENHANCED_FEATURE: enhanced_feature <= wdata_in;
        UFC_OFF_RX_LEVEL_SETTING: rx_level_setting <= wdata_in;
        UFC_OFF_TX_LEVEL_SETTING: tx_level_setting <= wdata_in;
        UFC_OFF_FLOW_THRESHOLD_LOW: flow_threshold_low <= wdata_in;
        UFC_OFF_FLOW_THRESHOLD_HIGH: flow_threshold_high <= wdata_in;
        default: ;
      endcase
    end
  end

  // fifo control; flush bits live one cycle then fall back by themselves
  always_ff @(posedge clk_sys_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      fifo_control <= UFC_RST_REG; // [RULE11]
    end
    else if (fcr_write)
    begin
      fifo_control <= wdata_in;
    end
    else if (flush_state == UFC_FL_BUSY)
    begin
      fifo_control[UFC_FCR_TX_FLUSH] <= 1'b0; // [RULE9]
      fifo_control[UFC_FCR_RX_FLUSH] <= 1'b0; // [RULE10]
    end
  end

  always_comb
  begin
    next_flush_state = UFC_FL_IDLE;
    case (flush_state)
      UFC_FL_IDLE:
      begin
        if (fcr_write && (wdata_in[UFC_FCR_TX_FLUSH] || wdata_in[UFC_FCR_RX_FLUSH]))
        begin
          next_flush_state = UFC_FL_BUSY;
        end
      end
      UFC_FL_BUSY:
      begin
        if (fcr_write && (wdata_in[UFC_FCR_TX_FLUSH] || wdata_in[UFC_FCR_RX_FLUSH]))
        begin
          next_flush_state = UFC_FL_BUSY;
        end
      end
      default: next_flush_state = UFC_FL_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      flush_state <= UFC_FL_IDLE;
    end
    else
    begin
      flush_state <= next_flush_state;
    end
  end

  // flush pulses follow the written bits; datapath clears in that one cycle
  always_ff @(posedge clk_sys_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rx_flush_out <= 1'b0;
      tx_flush_out <= 1'b0;
      fifo_enable_out <= 1'b0;
    end
    else
    begin
      tx_flush_out <= fcr_write && wdata_in[UFC_FCR_TX_FLUSH]; // [RULE9]
      rx_flush_out <= fcr_write && wdata_in[UFC_FCR_RX_FLUSH]; // [RULE10]
      fifo_enable_out <= fcr_write ? wdata_in[UFC_FCR_ENABLE]
                                   : fifo_control[UFC_FCR_ENABLE]; // [RULE11]
    end
  end

  // transmit holding writes pass straight to the datapath
  always_ff @(posedge clk_sys_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tx_write_out <= 1'b0;
      tx_data_out <= UFC_RST_REG;
    end
    else
    begin
      tx_write_out <= wr_in && (addr_in == UFC_OFF_TX_HOLDING);
      if (wr_in && (addr_in == UFC_OFF_TX_HOLDING))
      begin
        tx_data_out <= wdata_in;
      end
    end
  end

  // trigger level selection
  assign use_level_regs = (rx_level_setting != 8'h00) || (tx_level_setting != 8'h00) ||
                          (flow_threshold_low != 8'h00) ||
                          (flow_threshold_high != 8'h00); // [RULE12]

  always_comb
  begin
    rx_trig = UFC_RX_TRIG_0;
    tx_trig = UFC_TX_TRIG_0;
    case (fifo_control[UFC_FCR_RX_TRIG_LSB +: 2]) // [RULE7]
      2'h0: rx_trig = UFC_RX_TRIG_0;
      2'h1: rx_trig = UFC_RX_TRIG_1;
      2'h2: rx_trig = UFC_RX_TRIG_2;
      default: rx_trig = UFC_RX_TRIG_3;
    endcase
    case (fifo_control[UFC_FCR_TX_TRIG_LSB +: 2]) // [RULE8]
      2'h0: tx_trig = UFC_TX_TRIG_0;
      2'h1: tx_trig = UFC_TX_TRIG_1;
      2'h2: tx_trig = UFC_TX_TRIG_2;
      default: tx_trig = UFC_TX_TRIG_3;
    endcase
    if (use_level_regs)
    begin
      rx_trig = rx_level_setting; // [RULE12]
      tx_trig = tx_level_setting; // [RULE12]
    end
  end

  // rx ready is a pure level so it drops the moment the count falls below
  assign rx_ready_pend = fifo_control[UFC_FCR_ENABLE] ?
                         (rx_count_in >= rx_trig) : (rx_count_in != 8'h00); // [RULE7] [RULE20]

  // non-fifo mode treats the holding register as empty only at zero
  assign tx_below = fifo_control[UFC_FCR_ENABLE] ?
                    (tx_count_in < tx_trig) : (tx_count_in == 8'h00); // [RULE8]

  // receive error bits; a new error in the read cycle survives the clear
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_err
      always_ff @(posedge clk_sys_in or negedge rst_n)
      begin
        if (!rst_n)
        begin
          line_err[gi] <= 1'b0;
        end
        else if (rx_error_in[gi])
        begin
          line_err[gi] <= 1'b1; // [RULE3]
        end
        else if (ls_read)
        begin
          line_err[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  // tx empty: set on falling below trigger, cleared by an id read that reports it or by a holding write
  always_ff @(posedge clk_sys_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tx_below_q <= 1'b0;
      tx_empty_pend <= 1'b0;
    end
    else
    begin
      tx_below_q <= tx_below;
      if (tx_below && !tx_below_q)
      begin
        tx_empty_pend <= 1'b1; // [RULE8]
      end
      else if ((id_read && (next_id == UFC_ID_TX_EMPTY)) ||
               (wr_in && (addr_in == UFC_OFF_TX_HOLDING)))
      begin
        tx_empty_pend <= 1'b0; // [RULE21]
      end
    end
  end

  // xoff stays until xon; cts/rts change clears once reported
  always_ff @(posedge clk_sys_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      xoff_pend <= 1'b0;
      cts_rts_pend <= 1'b0;
    end
    else
    begin
      if (xoff_match_in && enhanced_feature[UFC_EF_ENHANCED])
      begin
        xoff_pend <= 1'b1; // [RULE17]
      end
      else if (xon_match_in)
      begin
        xoff_pend <= 1'b0; // [RULE18]
      end
      if (cts_rts_event_in && enhanced_feature[UFC_EF_ENHANCED])
      begin
        cts_rts_pend <= 1'b1; // [RULE17]
      end
      else if (id_read && (next_id == UFC_ID_CTS_RTS))
      begin
        cts_rts_pend <= 1'b0;
      end
    end
  end

  // polled mode keeps every source quiet on the interrupt path
  assign polled = fifo_control[UFC_FCR_ENABLE] && (interrupt_mask[3:0] == 4'h0); // [RULE1]

  // priority encoder, highest first
  always_comb
  begin
    next_id = UFC_ID_NONE; // [RULE19]
    if (!polled)
    begin
      if (interrupt_mask[UFC_IM_LINE] && (line_err != 4'h0))
      begin
        next_id = UFC_ID_LINE; // [RULE14] [RULE13]
      end
      else if (interrupt_mask[UFC_IM_RX] && rx_ready_pend)
      begin
        next_id = UFC_ID_RX_DATA; // [RULE14]
      end
      else if (interrupt_mask[UFC_IM_RX] && rx_timeout_in)
      begin
        next_id = UFC_ID_RX_TIMEOUT; // [RULE14]
      end
      else if (interrupt_mask[UFC_IM_TX] && tx_empty_pend)
      begin
        next_id = UFC_ID_TX_EMPTY; // [RULE15]
      end
      else if (interrupt_mask[UFC_IM_MODEM] && modem_change_in)
      begin
        next_id = UFC_ID_MODEM; // [RULE15]
      end
      else if (enhanced_feature[UFC_EF_ENHANCED] && interrupt_mask[UFC_IM_XOFF] && xoff_pend)
      begin
        next_id = UFC_ID_XOFF; // [RULE15] [RULE17]
      end
      else if (enhanced_feature[UFC_EF_ENHANCED] &&
               (interrupt_mask[UFC_IM_RTS] || interrupt_mask[UFC_IM_CTS]) && cts_rts_pend)
      begin
        next_id = UFC_ID_CTS_RTS; // [RULE15] [RULE17]
      end
    end
  end

  assign any_pend = (next_id != UFC_ID_NONE); // [RULE22]
  assign id_value = {{2{fifo_control[UFC_FCR_ENABLE]}}, next_id}; // [RULE16]

  assign line_state = {rx_fifo_error_in, // [RULE6]
                       (tx_count_in == 8'h00) && tx_shift_empty_in, // [RULE5]
                       (tx_count_in == 8'h00), // [RULE4]
                       line_err, // [RULE3]
                       (rx_count_in != 8'h00)}; // [RULE2]

  // interrupt output from a flop, one cycle behind the encoder
  always_ff @(posedge clk_sys_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      irq_out <= 1'b0;
    end
    else
    begin
      irq_out <= any_pend; // [RULE22] [RULE1]
    end
  end

  // read data valid the cycle after the strobe; unmapped reads give zero
  always_ff @(posedge clk_sys_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rdata_out <= UFC_RST_REG;
    end
    else if (rd_in)
    begin
      case (addr_in)
        UFC_OFF_INTERRUPT_MASK: rdata_out <= interrupt_mask;
        UFC_OFF_INTERRUPT_ID: rdata_out <= id_value; // [RULE13]
        UFC_OFF_LINE_STATE: rdata_out <= line_state;
        UFC_OFF_ENHANCED_FEATURE: rdata_out <= enhanced_feature;
        UFC_OFF_RX_LEVEL_SETTING: rdata_out <= rx_level_setting;
        UFC_OFF_TX_LEVEL_SETTING: rdata_out <= tx_level_setting;
        UFC_OFF_FLOW_THRESHOLD_LOW: rdata_out <= flow_threshold_low;
        UFC_OFF_FLOW_THRESHOLD_HIGH: rdata_out <= flow_threshold_high;
        UFC_OFF_FIFO_CONTROL_SHADOW: rdata_out <= fifo_control;
        default: rdata_out <= UFC_RST_REG;
      endcase
    end
    else
    begin
      rdata_out <= UFC_RST_REG;
    end
  end
endmodule // ufc_top

// ---- ufc_top_chk.sv ----
`timescale 1ns/1ps
module ufc_top_chk
  import ufc_pkg::*;
(
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic rstn_in,
  // register port
  input wire logic [3:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic [7:0] rdata_out,
  // datapath side
  input wire logic [7:0] rx_count_in,
  input wire logic [7:0] tx_count_in,
  input wire logic tx_shift_empty_in,
  input wire logic rx_fifo_error_in,
  input wire logic fifo_enable_out,
  input wire logic rx_flush_out,
  input wire logic tx_flush_out,
  input wire logic tx_write_out,
  input wire logic [7:0] tx_data_out,
  input wire logic irq_out
);
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!rstn_in);
  logic fcr_wr;
  logic id_rd;
  logic ls_rd;
  assign fcr_wr = wr_in && addr_in == UFC_OFF_FIFO_CONTROL;
  assign id_rd = rd_in && addr_in == UFC_OFF_INTERRUPT_ID;
  assign ls_rd = rd_in && addr_in == UFC_OFF_LINE_STATE;
  a_rdata_quiet: assert property (!rd_in |=> rdata_out == 8'h00)
    else $error("read data not zero outside a read");
  // a second flush write right behind the first legally keeps the pulse up
  a_rx_flush_pulse: assert property (fcr_wr && wdata_in[1] |=> rx_flush_out
    ##1 (!rx_flush_out || $past(fcr_wr && wdata_in[1])))
    else $error("rx flush pulse wrong");
  a_tx_flush_pulse: assert property (fcr_wr && wdata_in[2] |=> tx_flush_out
    ##1 (!tx_flush_out || $past(fcr_wr && wdata_in[2])))
    else $error("tx flush pulse wrong");
  a_fifo_en_set: assert property (fcr_wr |=> fifo_enable_out == $past(wdata_in[0]))
    else $error("fifo enable not taken from write");
  a_fifo_en_hold: assert property (!fcr_wr |=> $stable(fifo_enable_out))
    else $error("fifo enable changed without write");
  a_id_fifo_bits: assert property (id_rd |=> rdata_out[7:6] == {2{fifo_enable_out}})
    else $error("id bits 7:6 wrong");
  a_id_irq_match: assert property (id_rd |=> rdata_out[0] == !irq_out)
    else $error("id bit 0 disagrees with irq");
  a_ls_rx_bits: assert property (ls_rd |=> rdata_out[0] == ($past(rx_count_in) != 8'h00)
    && rdata_out[7] == $past(rx_fifo_error_in))
    else $error("line state rx bits wrong");
  a_ls_tx_bits: assert property (ls_rd |=> rdata_out[5] == ($past(tx_count_in) == 8'h00)
    && rdata_out[6] == ($past(tx_count_in) == 8'h00 && $past(tx_shift_empty_in)))
    else $error("line state tx bits wrong");
  a_tx_write_copy: assert property (wr_in && addr_in == UFC_OFF_TX_HOLDING
    |=> tx_write_out && tx_data_out == $past(wdata_in))
    else $error("tx holding write not passed on");
endmodule // ufc_top_chk

bind ufc_top ufc_top_chk chk (
  .clk_sys_in(clk_sys_in),
  .rstn_in(rstn_in),
  .addr_in(addr_in),
  .wdata_in(wdata_in),
  .wr_in(wr_in),
  .rd_in(rd_in),
  .rdata_out(rdata_out),
  .rx_count_in(rx_count_in),
  .tx_count_in(tx_count_in),
  .tx_shift_empty_in(tx_shift_empty_in),
  .rx_fifo_error_in(rx_fifo_error_in),
  .fifo_enable_out(fifo_enable_out),
  .rx_flush_out(rx_flush_out),
  .tx_flush_out(tx_flush_out),
  .tx_write_out(tx_write_out),
  .tx_data_out(tx_data_out),
  .irq_out(irq_out)
);

// ---- ufc_host.sv ----
`timescale 1ns/1ps
module ufc_host
(
  // clock
  input wire logic clk_sys_in,
  // register port
  output logic [3:0] addr_out,
  output logic [7:0] wdata_out,
  output logic wr_out,
  output logic rd_out,
  input wire logic [7:0] rdata_in
);
  initial
  begin
    addr_out = 4'h0;
    wdata_out = 8'h00;
    wr_out = 1'b0;
    rd_out = 1'b0;
  end
  // one-cycle strobes; the slave never stalls, so no wait loop
  task automatic write_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys_in);
    addr_out <= a;
    wdata_out <= d;
    wr_out <= 1'b1;
    @(posedge clk_sys_in);
    wr_out <= 1'b0;
    wdata_out <= ~d;
  endtask
  task automatic read_reg(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk_sys_in);
    addr_out <= a;
    rd_out <= 1'b1;
    @(posedge clk_sys_in);
    rd_out <= 1'b0;
    #1;
    d = rdata_in;
  endtask
endmodule // ufc_host

// ---- uart_fifo_ctrl_int_status_test.sv ----
`timescale 1ns/1ps
module uart_fifo_ctrl_int_status_test;
  import ufc_pkg::*;
  logic clk_sys_in = 1'b0;
  logic rstn_in = 1'b0;
  logic [3:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic [7:0] tx_data;
  logic [7:0] rx_count = 8'h00;
  logic [7:0] tx_count = 8'hff;
  logic wr;
  logic rd;
  logic shift_empty = 1'b1;
  logic fifo_err = 1'b0;
  logic timeout = 1'b0;
  logic modem = 1'b0;
  logic [6:0] ev = 7'h00;
  logic fifo_en;
  logic irq;
  int error_cnt = 0;
  int num_checks = 0;
  int cyc = 0;

  always #10 clk_sys_in = ~clk_sys_in;

  ufc_host host (.clk_sys_in(clk_sys_in), .addr_out(addr), .wdata_out(wdata), .wr_out(wr),
    .rd_out(rd), .rdata_in(rdata));

  ufc_top uut (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .addr_in(addr), .wdata_in(wdata),
    .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .rx_count_in(rx_count), .tx_count_in(tx_count),
    .tx_shift_empty_in(shift_empty), .rx_error_in(ev[3:0]), .rx_fifo_error_in(fifo_err),
    .rx_timeout_in(timeout), .modem_change_in(modem), .xoff_match_in(ev[4]),
    .xon_match_in(ev[5]), .cts_rts_event_in(ev[6]), .fifo_enable_out(fifo_en),
    .rx_flush_out(), .tx_flush_out(), .tx_write_out(), .tx_data_out(tx_data), .irq_out(irq));

  task automatic close_out;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic rc(input logic [3:0] a, input logic [7:0] exp, input string what);
    logic [7:0] d;
    host.read_reg(a, d);
    chk(what, exp, d);
  endtask

  // event pulses last exactly one cycle, as the datapath gives them
  task automatic pev(input logic [6:0] v);
    @(posedge clk_sys_in);
    ev <= v;
    @(posedge clk_sys_in);
    ev <= 7'h00;
  endtask

  task automatic t_fcr;
    rc(UFC_OFF_INTERRUPT_ID, 8'h01, "id reset");
    rc(UFC_OFF_FIFO_CONTROL_SHADOW, 8'h00, "fcr reset");
    host.write_reg(UFC_OFF_FIFO_CONTROL, 8'h07);
    rc(UFC_OFF_FIFO_CONTROL_SHADOW, 8'h01, "fcr self clear");
    chk("fifo_en", 8'h01, {7'h00, fifo_en});
    rc(UFC_OFF_INTERRUPT_ID, 8'hc1, "id fifo on");
    host.write_reg(UFC_OFF_FIFO_CONTROL, 8'h00);
    rc(UFC_OFF_INTERRUPT_ID, 8'h01, "id fifo off");
    $display("t_fcr done");
  endtask

  task automatic t_polled;
    host.write_reg(UFC_OFF_FIFO_CONTROL, 8'h01);
    host.write_reg(UFC_OFF_INTERRUPT_MASK, 8'h00);
    @(posedge clk_sys_in) rx_count <= 8'h1f;
    tx_count <= 8'h00;
    fifo_err <= 1'b1;
    pev(7'h04);
    rc(UFC_OFF_INTERRUPT_ID, 8'hc1, "id polled");
    chk("irq polled", 8'h00, {7'h00, irq});
    rc(UFC_OFF_LINE_STATE, 8'he9, "line state");
    @(posedge clk_sys_in) shift_empty <= 1'b0;
    rc(UFC_OFF_LINE_STATE, 8'ha1, "line state again");
    @(posedge clk_sys_in) rx_count <= 8'h00;
    tx_count <= 8'hff;
    fifo_err <= 1'b0;
    shift_empty <= 1'b1;
    host.write_reg(UFC_OFF_TX_HOLDING, 8'ha5);
    $display("t_polled done");
  endtask

  task automatic t_rx_trig;
    logic [7:0] lvl [4] = '{8'h08, 8'h10, 8'h18, 8'h1c};
    host.write_reg(UFC_OFF_INTERRUPT_MASK, 8'h01);
    for (int k = 0; k < 4; k++)
    begin
      host.write_reg(UFC_OFF_FIFO_CONTROL, {k[1:0], 6'h01});
      @(posedge clk_sys_in) rx_count <= lvl[k] - 8'h01;
      rc(UFC_OFF_INTERRUPT_ID, 8'hc1, "rx below trigger");
      @(posedge clk_sys_in) rx_count <= lvl[k];
      rc(UFC_OFF_INTERRUPT_ID, 8'hc4, "rx at trigger");
      chk("irq rx", 8'h01, {7'h00, irq});
    end
    @(posedge clk_sys_in) rx_count <= 8'h1b;
    rc(UFC_OFF_INTERRUPT_ID, 8'hc1, "rx dropped");
    @(posedge clk_sys_in) rx_count <= 8'h00;
    $display("t_rx_trig done");
  endtask

  task automatic t_tx_trig;
    logic [7:0] lvl [4] = '{8'h10, 8'h08, 8'h18, 8'h1e};
    host.write_reg(UFC_OFF_INTERRUPT_MASK, 8'h02);
    for (int k = 0; k < 4; k++)
    begin
      host.write_reg(UFC_OFF_FIFO_CONTROL, {2'b00, k[1:0], 4'h1});
      @(posedge clk_sys_in) tx_count <= lvl[k];
      rc(UFC_OFF_INTERRUPT_ID, 8'hc1, "tx at trigger");
      @(posedge clk_sys_in) tx_count <= lvl[k] - 8'h01;
      rc(UFC_OFF_INTERRUPT_ID, 8'hc2, "tx below trigger");
      rc(UFC_OFF_INTERRUPT_ID, 8'hc1, "tx after id read");
      @(posedge clk_sys_in) tx_count <= 8'hff;
    end
    @(posedge clk_sys_in) tx_count <= 8'h00;
    repeat (3) @(posedge clk_sys_in);
    #1;
    chk("irq tx", 8'h01, {7'h00, irq});
    host.write_reg(UFC_OFF_TX_HOLDING, 8'h5a);
    rc(UFC_OFF_INTERRUPT_ID, 8'hc1, "tx after write");
    chk("tx data", 8'h5a, tx_data);
    @(posedge clk_sys_in) tx_count <= 8'hff;
    $display("t_tx_trig done");
  endtask

  task automatic t_prio;
    host.write_reg(UFC_OFF_FIFO_CONTROL, 8'h01);
    host.write_reg(UFC_OFF_INTERRUPT_MASK, 8'hef);
    pev(7'h10);
    rc(UFC_OFF_INTERRUPT_ID, 8'hc1, "xoff ignored");
    host.write_reg(UFC_OFF_ENHANCED_FEATURE, 8'h10);
    @(posedge clk_sys_in) rx_count <= 8'h08;
    tx_count <= 8'h00;
    modem <= 1'b1;
    pev(7'h42);
    rc(UFC_OFF_INTERRUPT_ID, 8'hc6, "line first");
    chk("irq any", 8'h01, {7'h00, irq});
    rc(UFC_OFF_LINE_STATE, 8'h65, "line state");
    rc(UFC_OFF_INTERRUPT_ID, 8'hc4, "rx next");
    @(posedge clk_sys_in) rx_count <= 8'h00;
    timeout <= 1'b1;
    rc(UFC_OFF_INTERRUPT_ID, 8'hcc, "rx timeout");
    @(posedge clk_sys_in) timeout <= 1'b0;
    rc(UFC_OFF_INTERRUPT_ID, 8'hc2, "tx empty");
    rc(UFC_OFF_INTERRUPT_ID, 8'hc0, "modem");
    @(posedge clk_sys_in) modem <= 1'b0;
    pev(7'h10);
    rc(UFC_OFF_INTERRUPT_ID, 8'hd0, "xoff");
    rc(UFC_OFF_INTERRUPT_ID, 8'hd0, "xoff held");
    pev(7'h20);
    rc(UFC_OFF_INTERRUPT_ID, 8'he0, "cts rts");
    rc(UFC_OFF_INTERRUPT_ID, 8'hc1, "none left");
    chk("irq none", 8'h00, {7'h00, irq});
    host.write_reg(UFC_OFF_RX_LEVEL_SETTING, 8'h05);
    @(posedge clk_sys_in) rx_count <= 8'h05;
    rc(UFC_OFF_INTERRUPT_ID, 8'hc4, "rx level reg");
    @(posedge clk_sys_in) rx_count <= 8'h04;
    rc(UFC_OFF_INTERRUPT_ID, 8'hc1, "below level reg");
    $display("t_prio done");
  endtask

  // a hang anywhere still ends in the one closing report
  always @(posedge clk_sys_in)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      error_cnt++;
      close_out;
    end
  end

  initial
  begin
    repeat (20) @(posedge clk_sys_in);
    rstn_in <= 1'b1;
    repeat (4) @(posedge clk_sys_in);
    t_fcr;
    t_polled;
    t_rx_trig;
    t_tx_trig;
    t_prio;
    close_out;
  end
endmodule // uart_fifo_ctrl_int_status_test
